// ==== hw/psc_pad_slew_config.sv ====
// pad slew and input-buffer control register with avalon-mm slave
`timescale 1ns/1ps

module psc_pad_slew_config (
   // clock and reset
   input  wire logic                       i_clk,
   input  wire logic                       i_rst_b,
   // avalon-mm slave
   input  wire logic [psc_pkg::ADDR_W-1:0] i_address,
   input  wire logic                       i_read,
   input  wire logic                       i_write,
   input  wire logic [31:0]                i_writedata,
   input  wire logic [3:0]                 i_byteenable,
   output logic      [31:0]                o_readdata,
   output logic                            o_waitrequest,
   // pad cell controls
   output psc_pkg::psc_port_s              o_porta,
   output psc_pkg::psc_port_s              o_portb
);

   logic [31:0]        ctrl_q;
   logic               ack_q;
   logic [31:0]        wmask;
   logic               hit;
   psc_pkg::psc_port_s porta_d;
   psc_pkg::psc_port_s portb_d;

   assign hit = (i_address == psc_pkg::PAD_CTRL_OFF);

   always_comb begin
      for (int b = 0; b < 4; b++) begin
         wmask[b*8 +: 8] = {8{i_byteenable[b]}};
      end
   end

   // one wait state per access: answer in the cycle after the request
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= (i_read || i_write) && !ack_q;
      end
   end

   // waitrequest has its own flop, in step with ack_q, so the pin comes
   // straight from a register and not through an inverter
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_waitrequest <= 1'b1;
      end else begin
         o_waitrequest <= !((i_read || i_write) && !ack_q);
      end
   end

   // write lands at the completing edge only
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         ctrl_q <= psc_pkg::PAD_CTRL_RST;
      end else if (i_write && ack_q && hit) begin
         ctrl_q <= ((ctrl_q & ~wmask) | (i_writedata & wmask))
                   & psc_pkg::PAD_CTRL_MASK;
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_readdata <= 32'h0000_0000;
      end else if (i_read && !ack_q) begin
         o_readdata <= hit ? ctrl_q : psc_pkg::UNMAPPED_READ;
      end
   end

   // fan each group bit out to its four pins; 1 fast/schmitt, 0 slow/cmos
   always_comb begin
      for (int g = 0; g < psc_pkg::GROUPS; g++) begin
         for (int p = 0; p < psc_pkg::PINS_PER_GROUP; p++) begin
            porta_d.fast_slew[g*4+p] =
               ctrl_q[psc_pkg::PORTA_LSB+2*g+1];
            porta_d.hysteresis_in[g*4+p] =
               ctrl_q[psc_pkg::PORTA_LSB+2*g];
            portb_d.fast_slew[g*4+p] =
               ctrl_q[psc_pkg::PORTB_LSB+2*g+1];
            portb_d.hysteresis_in[g*4+p] =
               ctrl_q[psc_pkg::PORTB_LSB+2*g];
         end
      end
   end

   // registered pad outputs, so they follow the register by one cycle
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_porta <= '1;
         o_portb <= '1;
      end else begin
         o_porta <= porta_d;
         o_portb <= portb_d;
      end
   end

   // pad outputs lag ctrl_q by one cycle, so fan-out checks use $past
   reset_value_a: assert property (
      @(posedge i_clk) $rose(i_rst_b) |-> ctrl_q == psc_pkg::PAD_CTRL_RST)
      else $error("bad reset value");

   low_half_zero_a: assert property (
      @(posedge i_clk) disable iff (!i_rst_b)
      ctrl_q[15:0] == 16'h0000)
      else $error("low half not zero");

   group_fanout_a: assert property (
      @(posedge i_clk) disable iff (!i_rst_b)
      o_portb.fast_slew[15:12] == {4{$past(ctrl_q[31])}})
      else $error("group fanout wrong");

   portb_slew_a: assert property (
      @(posedge i_clk) disable iff (!i_rst_b)
      o_portb.fast_slew[3:0] == {4{$past(ctrl_q[25])}})
      else $error("port b slew wrong");

   portb_slew_g1_a: assert property (
      @(posedge i_clk) disable iff (!i_rst_b)
      o_portb.fast_slew[7:4] == {4{$past(ctrl_q[27])}})
      else $error("port b group 1 slew wrong");

   portb_hyst_a: assert property (
      @(posedge i_clk) disable iff (!i_rst_b)
      o_portb.hysteresis_in[11:8] == {4{$past(ctrl_q[28])}})
      else $error("port b buffer wrong");

   portb_hyst_g3_a: assert property (
      @(posedge i_clk) disable iff (!i_rst_b)
      o_portb.hysteresis_in[15:12] == {4{$past(ctrl_q[30])}})
      else $error("port b group 3 buffer wrong");

   porta_slew_a: assert property (
      @(posedge i_clk) disable iff (!i_rst_b)
      o_porta.fast_slew[7:4] == {4{$past(ctrl_q[19])}})
      else $error("port a slew wrong");

   porta_slew_g2_a: assert property (
      @(posedge i_clk) disable iff (!i_rst_b)
      o_porta.fast_slew[11:8] == {4{$past(ctrl_q[21])}})
      else $error("port a group 2 slew wrong");

   porta_hyst_a: assert property (
      @(posedge i_clk) disable iff (!i_rst_b)
      o_porta.hysteresis_in[15:12] == {4{$past(ctrl_q[22])}})
      else $error("port a buffer wrong");

   porta_hyst_g0_a: assert property (
      @(posedge i_clk) disable iff (!i_rst_b)
      o_porta.hysteresis_in[3:0] == {4{$past(ctrl_q[16])}})
      else $error("port a group 0 buffer wrong");

   slow_slew_a: assert property (
      @(posedge i_clk) disable iff (!i_rst_b)
      (i_write && ack_q && hit && i_byteenable[2] && !i_writedata[17])
      |-> ##2 o_porta.fast_slew[3:0] == 4'h0)
      else $error("low slew not applied");

   fast_slew_a: assert property (
      @(posedge i_clk) disable iff (!i_rst_b)
      (i_write && ack_q && hit && i_byteenable[3] && i_writedata[31])
      |-> ##2 o_portb.fast_slew[15:12] == 4'hF)
      else $error("high slew not applied");

   cmos_in_a: assert property (
      @(posedge i_clk) disable iff (!i_rst_b)
      (i_write && ack_q && hit && i_byteenable[3] && !i_writedata[24])
      |-> ##2 o_portb.hysteresis_in[3:0] == 4'h0)
      else $error("cmos input not applied");

   schmitt_in_a: assert property (
      @(posedge i_clk) disable iff (!i_rst_b)
      (i_write && ack_q && hit && i_byteenable[2] && i_writedata[22])
      |-> ##2 o_porta.hysteresis_in[15:12] == 4'hF)
      else $error("schmitt input not applied");

   lane_keep_a: assert property (
      @(posedge i_clk) disable iff (!i_rst_b)
      (i_write && ack_q && hit && !i_byteenable[3])
      |=> ctrl_q[31:24] == $past(ctrl_q[31:24]))
      else $error("disabled lane written");

   unmapped_write_a: assert property (
      @(posedge i_clk) disable iff (!i_rst_b)
      (i_write && !o_waitrequest && !hit) |=> $stable(ctrl_q))
      else $error("unmapped write landed");

   read_back_a: assert property (
      @(posedge i_clk) disable iff (!i_rst_b)
      (i_read && !o_waitrequest && hit) |-> o_readdata == $past(ctrl_q))
      else $error("read data wrong");

   unmapped_read_a: assert property (
      @(posedge i_clk) disable iff (!i_rst_b)
      (i_read && !o_waitrequest && !hit)
      |-> o_readdata == psc_pkg::UNMAPPED_READ)
      else $error("unmapped read not zero");

   bus_answer_a: assert property (
      @(posedge i_clk) disable iff (!i_rst_b)
      ((i_read || i_write) && o_waitrequest) |=> !o_waitrequest)
      else $error("no answer in one cycle");

   answer_once_a: assert property (
      @(posedge i_clk) disable iff (!i_rst_b)
      !o_waitrequest |=> o_waitrequest)
      else $error("answer longer than one cycle");

   idle_wait_a: assert property (
      @(posedge i_clk) disable iff (!i_rst_b)
      !(i_read || i_write) |=> o_waitrequest)
      else $error("answer without request");

endmodule : psc_pad_slew_config

// ==== hw/psc_pkg.sv ====
// package: offsets, field layout and reset value of the pad control block
package psc_pkg;
   localparam int          ADDR_W         = 8;
   localparam logic [7:0]  PAD_CTRL_OFF   = 8'h30;
   localparam logic [31:0] PAD_CTRL_RST   = 32'hFFFF_0000;
   localparam logic [31:0] PAD_CTRL_MASK  = 32'hFFFF_0000;
   localparam logic [31:0] UNMAPPED_READ  = 32'h0000_0000;
   localparam int          PORTA_LSB      = 16;
   localparam int          PORTB_LSB      = 24;
   localparam int          GROUPS         = 4;
   localparam int          PINS_PER_GROUP = 4;
   localparam int          PINS           = 16;

   // per-port pad settings, one bit per pin
   typedef struct packed {
      logic [15:0] fast_slew;
      logic [15:0] hysteresis_in;
   } psc_port_s;
endpackage : psc_pkg

// ==== testbench/testbench.sv ====
// self-checking bench for the pad slew and input-buffer control block
`timescale 1ns/1ps
module testbench;
   logic               i_clk, i_rst_b, i_read, i_write, o_waitrequest;
   logic [7:0]         i_address;
   logic [3:0]         i_byteenable, be;
   logic [31:0]        i_writedata, o_readdata, shadow, rd, d;
   psc_pkg::psc_port_s o_porta, o_portb;
   int                 mismatches, checked;
   logic [31:0]        corner[4] = '{32'h0000_FFFF, 32'hAAAA_AAAA,
                                     32'h5555_5555, 32'hFFFF_FFFF};
   psc_pad_slew_config uut (.i_clk(i_clk), .i_rst_b(i_rst_b),
      .i_address(i_address), .i_read(i_read), .i_write(i_write),
      .i_writedata(i_writedata), .i_byteenable(i_byteenable),
      .o_readdata(o_readdata), .o_waitrequest(o_waitrequest),
      .o_porta(o_porta), .o_portb(o_portb));
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task automatic close_out();
      $display("mismatches=%0d checked=%0d", mismatches, checked);
      if (mismatches == 0 && checked > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : close_out
   // holds the request until waitrequest is seen low, then releases it
   task automatic bus(input logic wr, input logic [7:0] a,
                      input logic [31:0] wd, input logic [3:0] en);
      @(posedge i_clk);
      i_read <= !wr;
      i_write <= wr;
      i_address <= a;
      i_writedata <= wd;
      i_byteenable <= en;
      do begin
         @(posedge i_clk);
      end while (o_waitrequest !== 1'b0);
      rd = o_readdata;
      i_read <= 1'b0;
      i_write <= 1'b0;
   endtask : bus
   // one pad bit per pin, copied from the group's register bit
   function automatic psc_pkg::psc_port_s pads(input logic [31:0] r,
                                                input int lsb);
      for (int p = 0; p < 16; p++) begin
         pads.fast_slew[p] = r[lsb + 2 * (p / 4) + 1];
         pads.hysteresis_in[p] = r[lsb + 2 * (p / 4)];
      end
   endfunction : pads
   task automatic verify();
      bus(1'b0, psc_pkg::PAD_CTRL_OFF, 32'h0, 4'hF);
      check(rd, shadow);
      check(o_porta, pads(shadow, 16));
      check(o_portb, pads(shadow, 24));
   endtask : verify
   initial begin
      i_clk = 1'b0;
      forever #20 i_clk = ~i_clk;
   end
   initial begin
      repeat (8000) @(posedge i_clk);
      mismatches++;
      close_out();
   end
   initial begin
      {i_rst_b, i_read, i_write, i_address, i_writedata, i_byteenable} = '0;
      shadow = psc_pkg::PAD_CTRL_RST;
      void'($urandom(32'h65fe9d61));
      repeat (12) @(posedge i_clk);
      i_rst_b <= 1'b1;
      verify();
      // unmapped places: write dropped, reads give zero
      bus(1'b1, 8'h34, 32'h0, 4'hF);
      bus(1'b0, 8'h00, 32'h0, 4'hF);
      check(rd, 32'h0);
      bus(1'b0, 8'h34, 32'h0, 4'hF);
      check(rd, 32'h0);
      verify();
      for (int i = 0; i < 44; i++) begin
         d = (i < 4) ? corner[i] : $urandom;
         be = (i < 4) ? 4'hF : 4'($urandom);
         bus(1'b1, psc_pkg::PAD_CTRL_OFF, d, be);
         for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
               shadow[8*b +: 8] = d[8*b +: 8];
            end
         end
         shadow = shadow & 32'hFFFF_0000;
         verify();
      end
      // reset in mid-run: register and pads return to their start value
      i_rst_b <= 1'b0;
      repeat (3) @(posedge i_clk);
      i_rst_b <= 1'b1;
      shadow = psc_pkg::PAD_CTRL_RST;
      verify();
      close_out();
   end
endmodule : testbench
